// File: drs_pkg.sv
// Constants, register map and types for the reference selection and DPLL mode control
package drs_pkg;
   localparam int NIN = 5;
   typedef logic [2:0] drs_idx_t;
   typedef logic [3:0] drs_num_t;
   // Input numbers by internal index: three, four, five, six, nine
   localparam logic [19:0] IN_NUMS = {4'h9, 4'h6, 4'h5, 4'h4, 4'h3};
   localparam drs_idx_t IDX_NONE = 3'h7;
   localparam drs_idx_t IDX_THREE = 3'h0;
   localparam drs_idx_t IDX_FOUR = 3'h1;
   localparam drs_idx_t IDX_FIVE = 3'h2;
   localparam drs_idx_t IDX_SIX = 3'h3;
   localparam drs_num_t NUM_NONE = 4'h0;
   localparam drs_num_t FORCE_AUTO_LO = 4'h0;
   localparam drs_num_t FORCE_AUTO_HI = 4'hf;
   // Word addresses of the register port
   localparam logic [4:0] A_CTRL_ONE = 5'h00;
   localparam logic [4:0] A_CTRL_TWO = 5'h01;
   localparam logic [4:0] A_CTRL_THREE = 5'h02;
   localparam logic [4:0] A_CTRL_FOUR = 5'h03;
   localparam logic [4:0] A_CTRL_TEN = 5'h04;
   localparam logic [4:0] A_CFG_ONE = 5'h05;
   localparam logic [4:0] A_PRIO = 5'h06;
   localparam logic [4:0] A_PTAB_ONE = 5'h07;
   localparam logic [4:0] A_PTAB_TWO = 5'h08;
   localparam logic [4:0] A_LATCHED_TWO = 5'h09;
   localparam logic [4:0] A_OPERATING_STATE_REG = 5'h0a;
   localparam logic [4:0] A_PHASE_LOCK_TIMEOUT = 5'h0b;
   localparam logic [4:0] A_FREQ_LIMIT = 5'h0c;
   localparam logic [4:0] A_MCLK_OFS = 5'h0d;
   localparam logic [4:0] A_VALID = 5'h0e;
   localparam logic [4:0] A_ISR = 5'h0f;
   // Control-ten and latched-two bit positions
   localparam int B_ULTRAFAST_SWITCH_EN = 0;
   localparam int B_EXT_SWITCH_MODE_EN = 1;
   localparam int B_PHASE_BUILDOUT_EN = 2;
   localparam int B_IEN_FAIL = 3;
   localparam int B_IEN_STATE = 4;
   localparam int B_FAIL = 0;
   localparam int B_STATE = 1;
   // Reset values; priorities three=2, four=3, five/six off, nine=5
   localparam logic [19:0] PRIO_RST = 20'h50032;
   localparam logic [7:0] PHASE_LOCK_TIMEOUT_DEF = 8'h64;
   // Frequency limit in 0.1 ppm units: 9.2, 80 and the 30 ppm slew bound
   localparam logic [9:0] FLIM_NORMAL = 10'h05c;
   localparam logic [9:0] FLIM_EXT_SWITCH_MODE_EN = 10'h320;
   localparam logic [9:0] FLIM_SLEW = 10'h12c;
   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int SEC_NS = 1000000000;
   localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
   localparam logic [1:0] LOCK_SEC = 2'h2;
   localparam logic [1:0] NOVALID_SEC = 2'h2;
   typedef enum logic [5:0] {
      ST_FREERUN = 6'h01,
      ST_PRELOCK = 6'h02,
      ST_PRELOCK2 = 6'h04,
      ST_LOCKED = 6'h08,
      ST_LOSSLOCK = 6'h10,
      ST_HOLDOVER = 6'h20
   } drs_state_t;
endpackage

// File: drs_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module drs_sync (
   input wire logic clk_sys_i,
   input wire logic pin_i,
   output logic level_o
);
   logic s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
   always_comb begin
      lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
   end
   // No reset: the level must flow during reset so it can be strapped
   always_ff @(posedge clk_sys_i) begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
   end
   assign level_o = lvl_r;
endmodule
`default_nettype wire

// File: drs_prio_sel.sv
// Priority table builder with forced-selection override
`timescale 1ns/1ps
`default_nettype none
module drs_prio_sel (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [19:0] prio_i,
   input wire logic [4:0] valid_i,
   input wire drs_pkg::drs_num_t force_i,
   output drs_pkg::drs_idx_t slot1_o,
   output drs_pkg::drs_idx_t slot2_o,
   output drs_pkg::drs_idx_t slot3_o
);
   import drs_pkg::*;
   drs_idx_t n [3];
   drs_idx_t fidx;
   logic forced;
   always_comb begin
      logic [4:0] taken;
      logic [4:0] bp;
      taken = '0;
      bp = '0;
      for (int k = 0; k < 3; k++) begin
         n[k] = IDX_NONE;
         bp = 5'h10;
         // Priority 0 disables; lower number wins, ties by index
         for (int i = 0; i < NIN; i++) begin
            if (valid_i[i] && !taken[i] && prio_i[i*4+:4] != 4'h0 && {1'b0, prio_i[i*4+:4]} < bp) begin
               bp = {1'b0, prio_i[i*4+:4]};
               n[k] = 3'(i);
            end
         end
         if (n[k] != IDX_NONE) taken[n[k]] = 1'b1;
      end
   end
   always_comb begin
      fidx = IDX_NONE;
      for (int i = 0; i < NIN; i++) begin
         if (IN_NUMS[i*4+:4] == force_i) fidx = 3'(i);
      end
      forced = force_i != FORCE_AUTO_LO && force_i != FORCE_AUTO_HI;
      // Forced input takes the top slot, normal order shifts down
      slot1_o = forced ? fidx : n[0];
      slot2_o = forced ? n[0] : n[1];
      slot3_o = forced ? n[1] : n[2];
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   AST_AUTO_TOP: assert property (!forced && slot1_o != IDX_NONE |-> valid_i[slot1_o] && prio_i[slot1_o*4+:4] != 4'h0)
      else $error("auto top slot wrong");
   AST_FORCE_SHIFT: assert property (forced |-> slot2_o == n[0] && slot3_o == n[1])
      else $error("forced table shift wrong");
   AST_BAD_FORCE: assert property (forced && fidx == IDX_NONE |-> slot1_o == IDX_NONE)
      else $error("invalid force selected input");
endmodule
`default_nettype wire

// File: drs_ref_ctrl.sv
// Reference selection and main DPLL mode controller with register port
`timescale 1ns/1ps
`default_nettype none
module drs_ref_ctrl #(
   parameter int TICK_CYCLES = drs_pkg::SEC_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [4:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic switch_select_pin_i,
   input wire logic [4:0] act_ok_i,
   input wire logic fast_noact_i,
   input wire logic phase_lock_i,
   output drs_pkg::drs_num_t main_sel_o,
   output drs_pkg::drs_num_t aux_sel_o,
   output drs_pkg::drs_state_t dpll_state_o,
   output logic freerun_o,
   output logic [15:0] master_clk_offset_o,
   output logic [9:0] freq_limit_o,
   output logic slew_limit_o,
   output logic [4:0] bucket_force_o,
   output logic irq_o
);
   import drs_pkg::*;
   logic pin_lvl;
   drs_idx_t top, second, third, sel_r, sel_nxt;
   // Registers
   logic [2:0] force_state_r, force_state_nxt;
   drs_num_t main_force_sel_r, main_force_sel_nxt, aux_force_sel_r, aux_force_sel_nxt;
   logic revertive_en_r, revertive_en_nxt, aux_phase_measure_en_r, aux_phase_measure_en_nxt;
   logic [4:0] ctrl_ten_r, ctrl_ten_nxt;
   logic [19:0] prio_r, prio_nxt;
   logic [1:0] latched_r, latched_nxt;
   logic [7:0] phase_lock_timeout_r, phase_lock_timeout_nxt;
   logic [9:0] flim_r, flim_nxt;
   logic [15:0] mclk_r, mclk_nxt;
   logic [4:0] alarm_r, alarm_nxt;
   logic [31:0] rdata_nxt;
   // State and timers
   drs_state_t st_r, st_nxt;
   logic [24:0] tick_r, tick_nxt;
   logic [7:0] to_r, to_nxt;
   logic [1:0] lock_r, lock_nxt, inval_r, inval_nxt;
   logic [4:0] bucket_nxt;
   logic [4:0] eff_valid;
   logic sec, cur_ok, any_valid, restart, uf_evt;
   logic ext, ultrafast_switch_en;
   drs_idx_t aux_idx;
   drs_num_t aux_num;

   drs_sync u_sync (
      .clk_sys_i(clk_sys_i),
      .pin_i(switch_select_pin_i),
      .level_o(pin_lvl)
   );

   // A phase-lock alarm invalidates the input until software clears it
   assign eff_valid = act_ok_i & ~alarm_r;
   assign any_valid = |eff_valid;
   assign ext = ctrl_ten_r[B_EXT_SWITCH_MODE_EN];
   assign ultrafast_switch_en = ctrl_ten_r[B_ULTRAFAST_SWITCH_EN];
   assign uf_evt = ultrafast_switch_en && fast_noact_i && sel_r != IDX_NONE;

   drs_prio_sel u_main_tab (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .prio_i(prio_r),
      .valid_i(eff_valid),
      .force_i(main_force_sel_r),
      .slot1_o(top),
      .slot2_o(second),
      .slot3_o(third)
   );

   always_comb begin
      cur_ok = sel_r != IDX_NONE && eff_valid[sel_r];
      if (ext) begin
         // Clock-switch behaviour: validity is ignored
         if (pin_lvl) begin
            sel_nxt = prio_r[IDX_THREE*4+:4] != 4'h0 ? IDX_THREE : IDX_FIVE;
         end else begin
            sel_nxt = prio_r[IDX_FOUR*4+:4] != 4'h0 ? IDX_FOUR : IDX_SIX;
         end
      end else if (revertive_en_r || !cur_ok || uf_evt) begin
         sel_nxt = top;
      end else begin
         sel_nxt = sel_r;
      end
   end

   // Aux DPLL: forced input, else the main table's top slot, which holds the main forced input when one is set
   always_comb begin
      aux_idx = IDX_NONE;
      for (int i = 0; i < NIN; i++) begin
         if (IN_NUMS[i*4+:4] == aux_force_sel_r) aux_idx = 3'(i);
      end
      if (aux_force_sel_r == FORCE_AUTO_LO || aux_force_sel_r == FORCE_AUTO_HI) begin
         aux_num = top == IDX_NONE ? NUM_NONE : IN_NUMS[top*4+:4];
      end else begin
         aux_num = aux_idx == IDX_NONE ? NUM_NONE : IN_NUMS[aux_idx*4+:4];
      end
   end

   always_comb begin
      sec = tick_r == 25'(TICK_CYCLES - 1);
      tick_nxt = sec ? '0 : tick_r + 25'h1;
      restart = 1'b0;
      st_nxt = st_r;
      // Software clear first, so a new alarm in the same cycle wins
      alarm_nxt = alarm_r & ~(wr_i && addr_i == A_ISR ? wdata_i[4:0] : 5'h0);
      bucket_nxt = '0;
      case (st_r)
         ST_FREERUN: begin
            if (any_valid) st_nxt = ST_PRELOCK;
         end
         ST_PRELOCK, ST_PRELOCK2, ST_LOSSLOCK: begin
            if (cur_ok && lock_r == LOCK_SEC) begin
               st_nxt = ST_LOCKED;
            end else if (to_r >= phase_lock_timeout_r && sel_r != IDX_NONE) begin
               alarm_nxt[sel_r] = 1'b1;
               restart = 1'b1;
               if (st_r == ST_LOSSLOCK) st_nxt = ST_PRELOCK2;
            end else if (!any_valid && inval_r == NOVALID_SEC) begin
               st_nxt = st_r == ST_PRELOCK ? ST_FREERUN : ST_HOLDOVER;
            end else if (sel_nxt != sel_r && sel_nxt != IDX_NONE) begin
               restart = 1'b1;
               if (st_r == ST_LOSSLOCK) st_nxt = ST_PRELOCK2;
            end
         end
         ST_LOCKED: begin
            if (!cur_ok) begin
               if (any_valid) st_nxt = ST_PRELOCK2;
               else if (inval_r == NOVALID_SEC) st_nxt = ST_HOLDOVER;
            end else if (!phase_lock_i) begin
               st_nxt = ST_LOSSLOCK;
            end
         end
         ST_HOLDOVER: begin
            if (any_valid) st_nxt = ST_PRELOCK2;
         end
         default: st_nxt = ST_FREERUN;
      endcase
      if (uf_evt && st_r != ST_FREERUN && st_r != ST_HOLDOVER) begin
         st_nxt = ST_PRELOCK2;
         restart = 1'b1;
         bucket_nxt[sel_r] = 1'b1;
      end
      case (force_state_r)
         3'h1: st_nxt = ST_FREERUN;
         3'h2: st_nxt = ST_HOLDOVER;
         3'h3: st_nxt = ST_LOCKED;
         3'h4: st_nxt = ST_PRELOCK;
         3'h5: st_nxt = ST_PRELOCK2;
         3'h6: st_nxt = ST_LOSSLOCK;
         default: ;
      endcase
      if (st_nxt != st_r) restart = 1'b1;
      to_nxt = restart ? '0 : (sec && to_r != 8'hff ? to_r + 8'h1 : to_r);
      lock_nxt = !phase_lock_i || restart ? '0 : (sec && lock_r != LOCK_SEC ? lock_r + 2'h1 : lock_r);
      inval_nxt = cur_ok || any_valid ? '0 : (sec && inval_r != NOVALID_SEC ? inval_r + 2'h1 : inval_r);
   end

   // Register port; flag sets win over software clears
   always_comb begin
      force_state_nxt = force_state_r;
      main_force_sel_nxt = main_force_sel_r;
      aux_force_sel_nxt = aux_force_sel_r;
      revertive_en_nxt = revertive_en_r;
      aux_phase_measure_en_nxt = aux_phase_measure_en_r;
      ctrl_ten_nxt = ctrl_ten_r;
      prio_nxt = prio_r;
      phase_lock_timeout_nxt = phase_lock_timeout_r;
      flim_nxt = flim_r;
      mclk_nxt = mclk_r;
      latched_nxt = latched_r;
      rdata_nxt = '0;
      if (wr_i) begin
         case (addr_i)
            A_CTRL_ONE: force_state_nxt = wdata_i[2:0];
            A_CTRL_TWO: main_force_sel_nxt = wdata_i[3:0];
            A_CTRL_THREE: revertive_en_nxt = wdata_i[0];
            A_CTRL_FOUR: aux_force_sel_nxt = wdata_i[3:0];
            A_CTRL_TEN: ctrl_ten_nxt = wdata_i[4:0];
            A_CFG_ONE: aux_phase_measure_en_nxt = wdata_i[0];
            A_PRIO: prio_nxt = wdata_i[19:0];
            A_LATCHED_TWO: latched_nxt = latched_r & ~wdata_i[1:0];
            A_PHASE_LOCK_TIMEOUT: phase_lock_timeout_nxt = wdata_i[7:0];
            A_FREQ_LIMIT: flim_nxt = wdata_i[9:0];
            A_MCLK_OFS: mclk_nxt = wdata_i[15:0];
            default: ;
         endcase
      end
      if (fast_noact_i) latched_nxt[B_FAIL] = 1'b1;
      if (st_nxt != st_r || restart) latched_nxt[B_STATE] = 1'b1;
      if (rd_i) begin
         case (addr_i)
            A_CTRL_ONE: rdata_nxt[2:0] = force_state_r;
            A_CTRL_TWO: rdata_nxt[3:0] = main_force_sel_r;
            A_CTRL_THREE: rdata_nxt[0] = revertive_en_r;
            A_CTRL_FOUR: rdata_nxt[3:0] = aux_force_sel_r;
            A_CTRL_TEN: rdata_nxt[4:0] = ctrl_ten_r;
            A_CFG_ONE: rdata_nxt[0] = aux_phase_measure_en_r;
            A_PRIO: rdata_nxt[19:0] = prio_r;
            A_PTAB_ONE: rdata_nxt[7:0] = {drs_num(top), drs_num(sel_r)};
            A_PTAB_TWO: rdata_nxt[7:0] = {drs_num(third), drs_num(second)};
            A_LATCHED_TWO: rdata_nxt[1:0] = latched_r;
            A_OPERATING_STATE_REG: rdata_nxt[5:0] = st_r;
            A_PHASE_LOCK_TIMEOUT: rdata_nxt[7:0] = phase_lock_timeout_r;
            A_FREQ_LIMIT: rdata_nxt[9:0] = flim_r;
            A_MCLK_OFS: rdata_nxt[15:0] = mclk_r;
            A_VALID: rdata_nxt[4:0] = eff_valid;
            A_ISR: rdata_nxt[4:0] = alarm_r;
            default: rdata_nxt = '0;
         endcase
      end
   end

   function automatic drs_num_t drs_num(input drs_idx_t idx);
      drs_num = idx == IDX_NONE ? NUM_NONE : IN_NUMS[idx*4+:4];
   endfunction

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         force_state_r <= '0;
         main_force_sel_r <= FORCE_AUTO_LO;
         aux_force_sel_r <= FORCE_AUTO_LO;
         revertive_en_r <= 1'b0;
         aux_phase_measure_en_r <= 1'b0;
         // External mode strapped from the pin while reset is held
         ctrl_ten_r <= {3'h0, pin_lvl, 1'b0};
         prio_r <= PRIO_RST;
         phase_lock_timeout_r <= PHASE_LOCK_TIMEOUT_DEF;
         flim_r <= pin_lvl ? FLIM_EXT_SWITCH_MODE_EN : FLIM_NORMAL;
         mclk_r <= '0;
         latched_r <= '0;
         alarm_r <= '0;
         st_r <= ST_FREERUN;
         sel_r <= IDX_NONE;
         tick_r <= '0;
         to_r <= '0;
         lock_r <= '0;
         inval_r <= '0;
         rdata_o <= '0;
         main_sel_o <= NUM_NONE;
         aux_sel_o <= NUM_NONE;
         dpll_state_o <= ST_FREERUN;
         freerun_o <= 1'b1;
         master_clk_offset_o <= '0;
         freq_limit_o <= FLIM_NORMAL;
         slew_limit_o <= 1'b0;
         bucket_force_o <= '0;
         irq_o <= 1'b0;
      end else begin
         force_state_r <= force_state_nxt;
         main_force_sel_r <= main_force_sel_nxt;
         aux_force_sel_r <= aux_force_sel_nxt;
         revertive_en_r <= revertive_en_nxt;
         aux_phase_measure_en_r <= aux_phase_measure_en_nxt;
         ctrl_ten_r <= ctrl_ten_nxt;
         prio_r <= prio_nxt;
         phase_lock_timeout_r <= phase_lock_timeout_nxt;
         flim_r <= flim_nxt;
         mclk_r <= mclk_nxt;
         latched_r <= latched_nxt;
         alarm_r <= alarm_nxt;
         st_r <= st_nxt;
         sel_r <= sel_nxt;
         tick_r <= tick_nxt;
         to_r <= to_nxt;
         lock_r <= lock_nxt;
         inval_r <= inval_nxt;
         rdata_o <= rdata_nxt;
         main_sel_o <= drs_num(sel_r);
         aux_sel_o <= aux_num;
         dpll_state_o <= st_r;
         freerun_o <= st_r == ST_FREERUN;
         master_clk_offset_o <= mclk_r;
         freq_limit_o <= flim_r;
         slew_limit_o <= ctrl_ten_r[B_PHASE_BUILDOUT_EN] || flim_r < FLIM_SLEW;
         bucket_force_o <= bucket_nxt;
         irq_o <= (latched_r[B_FAIL] && ctrl_ten_r[B_IEN_FAIL])
            || (latched_r[B_STATE] && ctrl_ten_r[B_IEN_STATE]);
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   AST_FREERUN_EXIT: assert property (st_r == ST_FREERUN && any_valid && force_state_r == 3'h0
      |=> st_r == ST_PRELOCK) else $error("free-run did not leave on valid input");
   AST_EXT_HIGH: assert property (ext && pin_lvl && prio_r[3:0] != 4'h0 |=> sel_r == IDX_THREE)
      else $error("external high did not pick three");
   AST_EXT_LOW: assert property (ext && !pin_lvl && prio_r[7:4] == 4'h0 |=> sel_r == IDX_SIX)
      else $error("external low did not fall back to six");
   AST_UF_STATE: assert property (uf_evt && st_r == ST_LOCKED && force_state_r == 3'h0
      |=> st_r == ST_PRELOCK2) else $error("ultrafast did not enter prelocked 2");
   AST_UF_BUCKET: assert property (uf_evt && st_r != ST_FREERUN && st_r != ST_HOLDOVER
      |=> bucket_force_o == 5'(1 << $past(sel_r)) ##1 (bucket_force_o == 5'h0 || $past(uf_evt)))
      else $error("bucket force pulse wrong");
   AST_FAIL_FLAG: assert property (fast_noact_i |=> latched_r[B_FAIL]) else $error("fail flag not set");
   AST_STATE_FLAG: assert property (st_r != $past(st_r) |-> latched_r[B_STATE])
      else $error("state change flag not set");
   AST_REVERTIVE_EN: assert property (revertive_en_r && !ext |=> sel_r == $past(top))
      else $error("revertive selection not top");
   AST_HOLD_SEL: assert property (!revertive_en_r && !ext && cur_ok && !uf_evt |=> sel_r == $past(sel_r))
      else $error("nonrevertive switched early");
   AST_SLEW: assert property (ctrl_ten_r[B_PHASE_BUILDOUT_EN] |=> slew_limit_o) else $error("slew limit not on");
   AST_RESET_FREE: assert property ($fell(rst_i) |-> st_r == ST_FREERUN ##1 freerun_o)
      else $error("not free-run after reset");
   COV_LOCK: cover property (st_r == ST_PRELOCK ##1 st_r == ST_LOCKED);
   COV_UF: cover property (uf_evt && st_r == ST_LOCKED);
   COV_EXT: cover property (ext && pin_lvl ##1 ext && !pin_lvl);
   COV_TIMEOUT: cover property (alarm_r != 5'h0);
endmodule
`default_nettype wire

// File: drs_ref_src.sv
// Model of the redundant timing-card reference clocks seen through their monitors
`timescale 1ns/1ps
`default_nettype none
module drs_ref_src (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [4:0] en_i,
   input wire logic lock_i,
   input wire logic miss_i,
   output logic [4:0] act_ok_o,
   output logic fast_noact_o,
   output logic phase_lock_o
);
   // Missing cycles also break phase lock for that cycle
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         act_ok_o <= 5'h00;
         fast_noact_o <= 1'b0;
         phase_lock_o <= 1'b0;
      end else begin
         act_ok_o <= en_i;
         fast_noact_o <= miss_i;
         phase_lock_o <= lock_i & ~miss_i;
      end
   end
endmodule
`default_nettype wire

// File: test_drs_ref_ctrl.sv
// Self-checking bench for the reference selection and DPLL mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(NM, EXP, GOT) begin samples_checked++; if ((GOT) !== (EXP)) begin bad_count++; \
   $display("unexpected %s expected %h seen %h", NM, EXP, GOT); end end
module test_drs_ref_ctrl;
   import drs_pkg::*;
   typedef struct {string nm; logic [31:0] v;} drs_note_t;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [4:0] addr_i = 5'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0, rd_i = 1'b0, pin = 1'b0, lock = 1'b0, miss = 1'b0, rd_d = 1'b0, bucket_seen = 1'b0;
   logic [4:0] en = 5'h00, act_ok, bucket;
   logic fast_noact, phase_lock, irq, slew, freerun;
   logic [31:0] rdata_o;
   logic [15:0] ofs;
   logic [9:0] flim;
   drs_num_t main_sel, aux_sel;
   drs_state_t state;
   int bad_count = 0;
   int samples_checked = 0;
   int seed = 32'h153f;
   drs_note_t notes[$];
   drs_note_t n;
   logic [3:0] fv [8] = '{4'h0, 4'hf, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'h7};
   logic [3:0] fe [8] = '{4'h3, 4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'h0};
   logic [19:0] pv [4] = '{20'h50032, 20'h50032, 20'h50030, 20'h50002};
   logic [3:0] xe [4] = '{4'h3, 4'h4, 4'h5, 4'h6};

   always #25 clk_sys_i = ~clk_sys_i;

   drs_ref_src far (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .en_i(en), .lock_i(lock), .miss_i(miss),
      .act_ok_o(act_ok), .fast_noact_o(fast_noact), .phase_lock_o(phase_lock));
   drs_ref_ctrl #(.TICK_CYCLES(10)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .switch_select_pin_i(pin),
      .act_ok_i(act_ok), .fast_noact_i(fast_noact), .phase_lock_i(phase_lock), .main_sel_o(main_sel),
      .aux_sel_o(aux_sel), .dpll_state_o(state), .freerun_o(freerun), .master_clk_offset_o(ofs),
      .freq_limit_o(flim), .slew_limit_o(slew), .bucket_force_o(bucket), .irq_o(irq));

   // Read results are judged one cycle after the strobe, oldest note first
   always @(posedge clk_sys_i) begin
      rd_d <= rd_i;
      if (bucket[0]) bucket_seen <= 1'b1;
      if (rd_d) begin
         if (notes.size() == 0) `CHK("note queue", 1'b1, 1'b0)
         else begin
            n = notes.pop_front();
            `CHK(n.nm, n.v, rdata_o)
         end
      end
   end

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      notes.push_back('{nm, e});
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
   endtask

   // Negative edge sampling keeps checks clear of the update edge
   task automatic idle(input int k);
      repeat (k) @(negedge clk_sys_i);
   endtask

   task automatic wait_state(input drs_state_t s, input int lim);
      for (int i = 0; i < lim && state !== s; i++) @(negedge clk_sys_i);
      `CHK("state", s, state)
   endtask

   task report_and_stop;
      $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
      if (bad_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #(50 * 40000);
      bad_count++;
      report_and_stop();
   end

   initial begin
      logic [31:0] r;
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      idle(1);
      `CHK("freerun", 1'b1, freerun)
      rd(A_OPERATING_STATE_REG, 32'(ST_FREERUN), "state");
      rd(A_FREQ_LIMIT, 32'(FLIM_NORMAL), "limit");
      rd(A_PRIO, 32'(PRIO_RST), "prio");
      rd(A_PHASE_LOCK_TIMEOUT, 32'(PHASE_LOCK_TIMEOUT_DEF), "timeout");
      r = $random(seed);
      wr({1'b1, r[3:0]}, r);
      rd({1'b1, r[3:0]}, 32'h0, "unmapped");
      r = $random(seed);
      wr(A_MCLK_OFS, {16'h0, r[15:0]});
      idle(2);
      `CHK("offset", r[15:0], ofs)
      `CHK("slew", 1'b1, slew)
      wr(A_FREQ_LIMIT, 32'(FLIM_SLEW));
      idle(2);
      `CHK("slew", 1'b0, slew)
      wr(A_CTRL_TEN, 32'h4);
      idle(2);
      `CHK("slew", 1'b1, slew)
      wr(A_CTRL_TEN, 32'h0);
      @(posedge clk_sys_i) en <= 5'h1f;
      wait_state(ST_PRELOCK, 20);
      idle(3);
      `CHK("main sel", 4'h3, main_sel)
      rd(A_PTAB_ONE, 32'h33, "ptab one");
      rd(A_PTAB_TWO, 32'h94, "ptab two");
      wr(A_CTRL_THREE, 32'h1);
      for (int i = 0; i < 8; i++) begin
         wr(A_CTRL_TWO, {28'h0, fv[i]});
         idle(3);
         `CHK("forced sel", fe[i], main_sel)
      end
      wr(A_CTRL_TWO, 32'h9);
      idle(3);
      rd(A_PTAB_ONE, 32'h99, "forced ptab one");
      rd(A_PTAB_TWO, 32'h43, "forced ptab two");
      // Back to automatic first so input three is selected again
      wr(A_CTRL_TWO, 32'h0);
      wr(A_CTRL_THREE, 32'h0);
      wr(A_CTRL_TWO, 32'h4);
      idle(3);
      `CHK("nonrev sel", 4'h3, main_sel)
      @(posedge clk_sys_i) en <= 5'h1e;
      idle(4);
      `CHK("nonrev sel", 4'h4, main_sel)
      @(posedge clk_sys_i) en <= 5'h1f;
      wr(A_CTRL_TWO, 32'h0);
      wr(A_CTRL_THREE, 32'h1);
      idle(3);
      wr(A_CTRL_FOUR, 32'h6);
      idle(3);
      `CHK("aux sel", 4'h6, aux_sel)
      wr(A_CFG_ONE, 32'h1);
      wr(A_CTRL_FOUR, 32'h9);
      idle(3);
      `CHK("aux sel", 4'h9, aux_sel)
      wr(A_CFG_ONE, 32'h0);
      wr(A_CTRL_FOUR, 32'h0);
      idle(3);
      `CHK("aux sel", 4'h3, aux_sel)
      @(posedge clk_sys_i) lock <= 1'b1;
      wait_state(ST_LOCKED, 80);
      wr(A_CTRL_THREE, 32'h0);
      wr(A_CTRL_TEN, 32'h9);
      wr(A_LATCHED_TWO, 32'h3);
      idle(2);
      `CHK("irq", 1'b0, irq)
      @(posedge clk_sys_i) miss <= 1'b1;
      @(posedge clk_sys_i) miss <= 1'b0;
      wait_state(ST_PRELOCK2, 6);
      idle(2);
      `CHK("bucket", 1'b1, bucket_seen)
      `CHK("irq", 1'b1, irq)
      rd(A_LATCHED_TWO, 32'h3, "latched");
      wr(A_LATCHED_TWO, 32'h3);
      idle(2);
      `CHK("irq", 1'b0, irq)
      @(posedge clk_sys_i) en <= 5'h00;
      wr(A_CTRL_TEN, 32'h2);
      for (int i = 0; i < 4; i++) begin
         wr(A_PRIO, {12'h0, pv[i]});
         @(posedge clk_sys_i) pin <= ~i[0];
         idle(8);
         `CHK("ext sel", xe[i], main_sel)
      end
      wr(A_CTRL_ONE, 32'h4);
      wait_state(ST_PRELOCK, 4);
      wr(A_CTRL_ONE, 32'h0);
      @(posedge clk_sys_i) rst_i <= 1'b1;
      pin <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      idle(1);
      rd(A_FREQ_LIMIT, 32'(FLIM_EXT_SWITCH_MODE_EN), "strap limit");
      rd(A_CTRL_TEN, 32'h2, "strap mode");
      rd(A_OPERATING_STATE_REG, 32'(ST_FREERUN), "state");
      idle(3);
      `CHK("limit out", FLIM_EXT_SWITCH_MODE_EN, flim)
      report_and_stop();
   end
endmodule
`default_nettype wire
